// ---- eifc_pkg.sv ----
// constants and types shared by the external interrupt and flag controller
`default_nettype none
package eifc_pkg;
   // register bus
   localparam int unsigned ADDR_W          = 2;
   localparam int unsigned DATA_W          = 8;
   localparam logic [1:0]  OFF_CONTROL     = 2'h0;
   localparam logic [1:0]  OFF_FLAGS       = 2'h1;
   localparam logic [1:0]  OFF_STATUS      = 2'h2;
   // interrupt_control fields
   localparam int unsigned BIT_PIN1_EN     = 7;
   localparam int unsigned BIT_PIN0_EN     = 6;
   localparam int unsigned BIT_LOW_EN      = 5;
   localparam int unsigned BIT_TOV_EN      = 4;
   localparam int unsigned BIT_PIN1_SENSE  = 2;
   localparam int unsigned BIT_PIN0_SENSE  = 0;
   // interrupt_flags fields
   localparam int unsigned BIT_PIN1_FLAG   = 7;
   localparam int unsigned BIT_PIN0_FLAG   = 6;
   localparam int unsigned BIT_TOV_FLAG    = 4;
   // status register: global enable
   localparam int unsigned BIT_GLOBAL_EN   = 7;
   // port pins shared with the external request inputs
   localparam int unsigned PORT_BIT_PIN0   = 3;
   localparam int unsigned PORT_BIT_PIN1   = 4;
   // program vector addresses
   localparam int unsigned VEC_W           = 10;
   localparam logic [9:0]  VEC_NONE        = 10'h000;
   localparam logic [9:0]  VEC_PIN0        = 10'h001;
   localparam logic [9:0]  VEC_PIN1        = 10'h002;
   localparam logic [9:0]  VEC_LOW_LEVEL   = 10'h003;
   localparam logic [9:0]  VEC_TIMER_OVF   = 10'h004;
   // reset values
   localparam logic [7:0]  RST_CONTROL     = 8'h00;
   localparam logic [7:0]  RST_PORT        = 8'hff;
   localparam logic        RST_PIN         = 1'b1;
   localparam logic        RST_FLAG        = 1'b0;
   localparam logic        RST_GLOBAL_EN   = 1'b0;
   localparam logic [7:0]  RST_RDATA       = 8'h00;
   // trigger selection for an external pin
   typedef enum logic [1:0] {
      EIFC_SENSE_LOW    = 2'b00,
      EIFC_SENSE_CHANGE = 2'b01,
      EIFC_SENSE_FALL   = 2'b10,
      EIFC_SENSE_RISE   = 2'b11
   } eifc_sense_e;
endpackage
`default_nettype wire

// ---- eifc_pin_sense.sv ----
// synchroniser and trigger decode for one external request pin
`timescale 1ns/10ps
`default_nettype none
module eifc_pin_sense (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   input  wire logic        i_pin,
   input  wire logic [1:0]  i_sense,
   output logic             o_edge_hit,
   output logic             o_pin_low
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic prev_reg,  prev_next;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sync1_next = i_pin;
      sync2_next = sync1_reg;
      prev_next  = sync2_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         sync1_reg <= eifc_pkg::RST_PIN;
         sync2_reg <= eifc_pkg::RST_PIN;
         prev_reg  <= eifc_pkg::RST_PIN;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg  <= prev_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // edges judged on synchronised samples only, so one clock of pulse suffices
   always_comb begin
      o_pin_low = !sync2_reg;
      case (i_sense)
         eifc_pkg::EIFC_SENSE_LOW:    o_edge_hit = 1'b0;                  // [R6] [R7]
         eifc_pkg::EIFC_SENSE_CHANGE: o_edge_hit = sync2_reg ^ prev_reg;  // [R6] [R7]
         eifc_pkg::EIFC_SENSE_FALL:   o_edge_hit = prev_reg & !sync2_reg; // [R6] [R7] [R9]
         eifc_pkg::EIFC_SENSE_RISE:   o_edge_hit = !prev_reg & sync2_reg; // [R6] [R7] [R9]
         default:                     o_edge_hit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- ext_irq_flag_control.sv ----
// external pin, port low-level and timer interrupt enables, flags and vectoring
// Notes on behaviour
// [R1] control bit 7 enables pin 1 request, vector $002 when globally enabled
// [R2] control bit 6 enables pin 0 request, vector $001 when globally enabled
// [R3] control bit 5 enables port low-level request, vector $003
// [R4] port pins busy with a special function never raise low-level requests
// [R5] control bit 4 with overflow flag and global enable vectors to $004
// [R6] pin 1 sense bits 3:2 pick low, change, falling or rising trigger
// [R7] pin 0 sense bits 1:0 use the same four trigger encodings
// [R8] software disables a pin before changing its sense field
// [R9] pins are synchronised before edge detection; pulses over one clock caught
// [R10] level mode keeps requesting while the pin stays low
// [R11] flag bit 7 sets on pin 1 edge, reads zero in level mode
// [R12] flag bit 6 sets on pin 0 edge, reads zero in level mode
// [R13] edge flags clear on vector taken or written one; zero leaves them
// [R14] flag bit 4 sets on overflow, clears on vector taken or written one
// [R15] flag bits 5 and 3..0 read zero and ignore writes
// [R16] lowest vector address wins: pin 0, pin 1, low level, overflow
// [R17] taking a vector clears global enable; return from interrupt sets it
// [R18] flags stay pending while disabled; level requests last only while active
// [R19] reset clears enables, sense fields, flags and global enable
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_flag_control (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   input  wire logic [1:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic        i_ext_pin0,
   input  wire logic        i_ext_pin1,
   input  wire logic [7:0]  i_port_pins,
   input  wire logic [7:0]  i_special_fn_mask,
   input  wire logic        i_timer_overflow,
   input  wire logic        i_irq_ack,
   input  wire logic        i_return_from_irq,
   output logic             o_irq_req,
   output logic      [9:0]  o_irq_vector,
   output logic             o_global_enable
);
   // set beats clear, so an event in the clearing cycle stays pending
   function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
      flag_upd = set | (cur & !clr);
   endfunction

   logic [7:0] ctrl_reg,      ctrl_next;
   logic       pin0_flag_reg, pin0_flag_next;
   logic       pin1_flag_reg, pin1_flag_next;
   logic       tov_flag_reg,  tov_flag_next;
   logic       gie_reg,       gie_next;
   logic [7:0] port_s1_reg,   port_s1_next;
   logic [7:0] port_s2_reg,   port_s2_next;
   logic [7:0] rdata_reg,     rdata_next;
   logic       req_reg,       req_next;
   logic [9:0] vec_reg,       vec_next;

   logic       pin0_hit;
   logic       pin1_hit;
   logic       pin0_low;
   logic       pin1_low;
   logic [1:0] sense0;
   logic [1:0] sense1;
   logic       lvl0;
   logic       lvl1;
   logic [7:0] port_mask;
   logic       low_any;
   logic       rq_pin0;
   logic       rq_pin1;
   logic       rq_low;
   logic       rq_tov;
   logic       wr_flags;
   logic       taken;

   ////////////////////////////////////////////////////////////////////////////////
   assign sense0 = ctrl_reg[eifc_pkg::BIT_PIN0_SENSE +: 2];
   assign sense1 = ctrl_reg[eifc_pkg::BIT_PIN1_SENSE +: 2];

   eifc_pin_sense u_pin0 (
      .i_clk_sys  (i_clk_sys),
      .i_rst_b    (i_rst_b),
      .i_pin      (i_ext_pin0),
      .i_sense    (sense0),
      .o_edge_hit (pin0_hit),
      .o_pin_low  (pin0_low)
   );

   eifc_pin_sense u_pin1 (
      .i_clk_sys  (i_clk_sys),
      .i_rst_b    (i_rst_b),
      .i_pin      (i_ext_pin1),
      .i_sense    (sense1),
      .o_edge_hit (pin1_hit),
      .o_pin_low  (pin1_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // request qualification and priority
   always_comb begin
      lvl0      = (sense0 == eifc_pkg::EIFC_SENSE_LOW);
      lvl1      = (sense1 == eifc_pkg::EIFC_SENSE_LOW);
      port_mask = i_special_fn_mask;                                        // [R4]
      port_mask[eifc_pkg::PORT_BIT_PIN0] = i_special_fn_mask[eifc_pkg::PORT_BIT_PIN0]
                                        | ctrl_reg[eifc_pkg::BIT_PIN0_EN];  // [R4]
      port_mask[eifc_pkg::PORT_BIT_PIN1] = i_special_fn_mask[eifc_pkg::PORT_BIT_PIN1]
                                        | ctrl_reg[eifc_pkg::BIT_PIN1_EN];  // [R4]
      low_any   = |(~port_s2_reg & ~port_mask);                             // [R3] [R4]
      rq_pin0   = ctrl_reg[eifc_pkg::BIT_PIN0_EN] & (lvl0 ? pin0_low : pin0_flag_reg); // [R2] [R10]
      rq_pin1   = ctrl_reg[eifc_pkg::BIT_PIN1_EN] & (lvl1 ? pin1_low : pin1_flag_reg); // [R1] [R10]
      rq_low    = ctrl_reg[eifc_pkg::BIT_LOW_EN] & low_any;                 // [R3] [R18]
      rq_tov    = ctrl_reg[eifc_pkg::BIT_TOV_EN] & tov_flag_reg;            // [R5]
      taken     = i_irq_ack & req_reg;
      // ack drops the request at once; core sees no stale vector
      req_next  = gie_reg & !taken & (rq_pin0 | rq_pin1 | rq_low | rq_tov); // [R1] [R2] [R3] [R5]
      if (rq_pin0) begin                                                    // [R16]
         vec_next = eifc_pkg::VEC_PIN0;
      end else if (rq_pin1) begin
         vec_next = eifc_pkg::VEC_PIN1;
      end else if (rq_low) begin
         vec_next = eifc_pkg::VEC_LOW_LEVEL;
      end else if (rq_tov) begin
         vec_next = eifc_pkg::VEC_TIMER_OVF;
      end else begin
         vec_next = eifc_pkg::VEC_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file, flags and global enable
   always_comb begin
      wr_flags     = i_wr && (i_addr == eifc_pkg::OFF_FLAGS);
      port_s1_next = i_port_pins;
      port_s2_next = port_s1_reg;
      ctrl_next    = ctrl_reg;
      if (i_wr && (i_addr == eifc_pkg::OFF_CONTROL)) begin
         ctrl_next = i_wdata;                                                // [R6] [R7]
      end
      // level mode keeps the edge flag at zero
      pin1_flag_next = lvl1 ? 1'b0 :                                         // [R11]
                       flag_upd(pin1_flag_reg, pin1_hit,                     // [R13]
                                (wr_flags & i_wdata[eifc_pkg::BIT_PIN1_FLAG])
                                | (taken & (vec_reg == eifc_pkg::VEC_PIN1)));
      pin0_flag_next = lvl0 ? 1'b0 :                                         // [R12]
                       flag_upd(pin0_flag_reg, pin0_hit,                     // [R13]
                                (wr_flags & i_wdata[eifc_pkg::BIT_PIN0_FLAG])
                                | (taken & (vec_reg == eifc_pkg::VEC_PIN0)));
      tov_flag_next  = flag_upd(tov_flag_reg, i_timer_overflow,             // [R14] [R18]
                                (wr_flags & i_wdata[eifc_pkg::BIT_TOV_FLAG])
                                | (taken & (vec_reg == eifc_pkg::VEC_TIMER_OVF)));
      if (taken) begin
         gie_next = 1'b0;                                                    // [R17]
      end else if (i_return_from_irq) begin
         gie_next = 1'b1;                                                    // [R17]
      end else if (i_wr && (i_addr == eifc_pkg::OFF_STATUS)) begin
         gie_next = i_wdata[eifc_pkg::BIT_GLOBAL_EN];
      end else begin
         gie_next = gie_reg;
      end
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            eifc_pkg::OFF_CONTROL: rdata_next = ctrl_reg;
            eifc_pkg::OFF_FLAGS: begin
               rdata_next[eifc_pkg::BIT_PIN1_FLAG] = pin1_flag_reg;          // [R15]
               rdata_next[eifc_pkg::BIT_PIN0_FLAG] = pin0_flag_reg;
               rdata_next[eifc_pkg::BIT_TOV_FLAG]  = tov_flag_reg;
            end
            eifc_pkg::OFF_STATUS: rdata_next[eifc_pkg::BIT_GLOBAL_EN] = gie_reg;
            default:             rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         ctrl_reg      <= eifc_pkg::RST_CONTROL;                             // [R19]
         pin0_flag_reg <= eifc_pkg::RST_FLAG;
         pin1_flag_reg <= eifc_pkg::RST_FLAG;
         tov_flag_reg  <= eifc_pkg::RST_FLAG;
         gie_reg       <= eifc_pkg::RST_GLOBAL_EN;
         port_s1_reg   <= eifc_pkg::RST_PORT;
         port_s2_reg   <= eifc_pkg::RST_PORT;
         rdata_reg     <= eifc_pkg::RST_RDATA;
         req_reg       <= 1'b0;
         vec_reg       <= eifc_pkg::VEC_NONE;
      end else begin
         ctrl_reg      <= ctrl_next;
         pin0_flag_reg <= pin0_flag_next;
         pin1_flag_reg <= pin1_flag_next;
         tov_flag_reg  <= tov_flag_next;
         gie_reg       <= gie_next;
         port_s1_reg   <= port_s1_next;
         port_s2_reg   <= port_s2_next;
         rdata_reg     <= rdata_next;
         req_reg       <= req_next;
         vec_reg       <= vec_next;
      end
   end

   assign o_rdata         = rdata_reg;
   assign o_irq_req       = req_reg;
   assign o_irq_vector    = vec_reg;
   assign o_global_enable = gie_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   property p_pin0_first;
      rq_pin0 && gie_reg && !taken |=> o_irq_req && (o_irq_vector == eifc_pkg::VEC_PIN0);
   endproperty
   a_pin0_first: assert property (p_pin0_first) else $error("pin 0 not served first"); // [R2]

   property p_pin1_vec;
      rq_pin1 && !rq_pin0 && gie_reg && !taken
         |=> o_irq_req && (o_irq_vector == eifc_pkg::VEC_PIN1);
   endproperty
   a_pin1_vec: assert property (p_pin1_vec) else $error("pin 1 vector wrong"); // [R1]

   property p_low_vec;
      gie_reg && ctrl_reg[eifc_pkg::BIT_LOW_EN] && low_any && !rq_pin0 && !rq_pin1 && !taken
         |=> (o_irq_vector == eifc_pkg::VEC_LOW_LEVEL);
   endproperty
   a_low_vec: assert property (p_low_vec) else $error("low level vector wrong"); // [R3]

   property p_masked_quiet;
      (&(port_s2_reg | i_special_fn_mask)) && !rq_pin0 && !rq_pin1 && !rq_tov
         |=> !o_irq_req;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("masked pin requested"); // [R4]

   property p_tov_vec;
      gie_reg && ctrl_reg[eifc_pkg::BIT_TOV_EN] && tov_flag_reg && !taken
         && !rq_pin0 && !rq_pin1 && !rq_low |=> (o_irq_vector == eifc_pkg::VEC_TIMER_OVF);
   endproperty
   a_tov_vec: assert property (p_tov_vec) else $error("overflow vector wrong"); // [R5]

   property p_level_hold;
      gie_reg && ctrl_reg[eifc_pkg::BIT_PIN0_EN] && lvl0 && pin0_low && !taken
         |=> o_irq_req;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level request dropped"); // [R10]

   property p_flag1_level_zero;
      lvl1 |=> !pin1_flag_reg;
   endproperty
   a_flag1_level_zero: assert property (p_flag1_level_zero) else $error("flag 1 set in level"); // [R11]

   property p_flag0_level_zero;
      lvl0 |=> !pin0_flag_reg;
   endproperty
   a_flag0_level_zero: assert property (p_flag0_level_zero) else $error("flag 0 set in level"); // [R12]

   property p_flag0_w1c;
      wr_flags && i_wdata[eifc_pkg::BIT_PIN0_FLAG] && !pin0_hit |=> !pin0_flag_reg;
   endproperty
   a_flag0_w1c: assert property (p_flag0_w1c) else $error("flag 0 not cleared"); // [R13]

   property p_tov_set;
      i_timer_overflow ##1 !i_timer_overflow |-> tov_flag_reg;
   endproperty
   a_tov_set: assert property (p_tov_set) else $error("overflow flag missed"); // [R14]

   property p_reserved_zero;
      i_rd && (i_addr == eifc_pkg::OFF_FLAGS) |=> (o_rdata[5] == 1'b0) && (o_rdata[3:0] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bits set"); // [R15]

   property p_ack_clears_gie;
      taken |=> !o_global_enable && !o_irq_req;
   endproperty
   a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("global enable kept"); // [R17]

   property p_return_sets_gie;
      i_return_from_irq && !taken |=> o_global_enable;
   endproperty
   a_return_sets_gie: assert property (p_return_sets_gie) else $error("global enable not set"); // [R17]

   property p_pending_kept;
      pin1_flag_reg && !lvl1 && !gie_reg && !wr_flags && !taken |=> pin1_flag_reg;
   endproperty
   a_pending_kept: assert property (p_pending_kept) else $error("pending flag lost"); // [R18]

   property p_reset_clear;
      $past(i_rst_b) == 1'b0 |-> (ctrl_reg == 8'h00) && !o_irq_req && !o_global_enable;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset"); // [R19]

   c_pin0_taken: cover property (o_irq_req && (o_irq_vector == eifc_pkg::VEC_PIN0) && i_irq_ack);
   c_tov_taken:  cover property (o_irq_req && (o_irq_vector == eifc_pkg::VEC_TIMER_OVF) && i_irq_ack);
   c_low_req:    cover property (o_irq_req && (o_irq_vector == eifc_pkg::VEC_LOW_LEVEL));
   c_return:     cover property (taken ##[1:20] i_return_from_irq);
endmodule
`default_nettype wire

// ---- eifc_core_model.sv ----
// behavioural model of the cpu core that takes interrupts and returns from them
`timescale 1ns/10ps
`default_nettype none
module eifc_core_model #(
   parameter int unsigned RET_DLY = 8
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   input  wire logic        i_irq_req,
   input  wire logic [2:0]  i_ack_delay,
   output logic             o_irq_ack,
   output logic             o_return_from_irq
);
   logic [2:0]  wait_cnt;
   logic [3:0]  ret_cnt;
   logic        in_handler;
   ////////////////////////////////////////////////////////////////////////////
   // ack after a chosen delay, then return a fixed time later;
   // never acks twice, because the handler runs until the return pulse
   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_irq_ack <= 1'b0;
         o_return_from_irq <= 1'b0;
         wait_cnt <= 3'h0;
         ret_cnt <= 4'h0;
         in_handler <= 1'b0;
      end else begin
         // each pulse written once per edge
         o_irq_ack <= !in_handler && i_irq_req && (wait_cnt >= i_ack_delay);
         o_return_from_irq <= in_handler && (ret_cnt == 4'h0);
         if (in_handler) begin
            if (ret_cnt == 4'h0) begin
               in_handler <= 1'b0;
            end else begin
               ret_cnt <= ret_cnt - 4'h1;
            end
         end else if (i_irq_req) begin
            if (wait_cnt >= i_ack_delay) begin
               in_handler <= 1'b1;
               ret_cnt <= RET_DLY[3:0];
               wait_cnt <= 3'h0;
            end else begin
               wait_cnt <= wait_cnt + 3'h1;
            end
         end else begin
            wait_cnt <= 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- ext_irq_flag_control_test.sv ----
// self-checking testbench of the external interrupt and flag controller
`timescale 1ns/10ps
`default_nettype none
module ext_irq_flag_control_test;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [1:0]  i_addr = 2'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [7:0]  o_rdata;
   logic        i_ext_pin0 = 1'b1;
   logic        i_ext_pin1 = 1'b1;
   logic [7:0]  i_port_pins = 8'hff;
   logic [7:0]  i_special_fn_mask = 8'h00;
   logic        i_timer_overflow = 1'b0;
   logic        i_irq_ack;
   logic        i_return_from_irq;
   logic        o_irq_req;
   logic [9:0]  o_irq_vector;
   logic        o_global_enable;
   logic [2:0]  ack_delay = 3'h0;
   logic        rd_seen = 1'b0;
   logic        ack_seen = 1'b0;
   logic [9:0]  exp_rd[$];
   logic [9:0]  exp_vec[$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          seed = 17317;
   int          w;
   logic [7:0]  rv;
   logic [7:0]  fmask;

   always #10 i_clk_sys = ~i_clk_sys;

   ext_irq_flag_control DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_ext_pin0(i_ext_pin0), .i_ext_pin1(i_ext_pin1), .i_port_pins(i_port_pins),
      .i_special_fn_mask(i_special_fn_mask), .i_timer_overflow(i_timer_overflow),
      .i_irq_ack(i_irq_ack), .i_return_from_irq(i_return_from_irq), .o_irq_req(o_irq_req),
      .o_irq_vector(o_irq_vector), .o_global_enable(o_global_enable));

   eifc_core_model u_core (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_irq_req(o_irq_req),
      .i_ack_delay(ack_delay), .o_irq_ack(i_irq_ack), .o_return_from_irq(i_return_from_irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_rd.push_back({2'h0, exp});
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
   endtask

   task automatic setpin(input int p, input logic v);
      @(posedge i_clk_sys);
      if (p == 1) i_ext_pin1 <= v;
      else i_ext_pin0 <= v;
   endtask

   // bounded wait for every noted vector to be taken
   task automatic wait_taken();
      for (int k = 0; k < 300 && exp_vec.size() != 0; k++) @(posedge i_clk_sys);
      if (exp_vec.size() != 0) cmp(10'h3ff, exp_vec[0]);
   endtask

   // then let the handler return
   task automatic wait_done();
      wait_taken();
      cyc(14);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // monitor: read data one cycle after the strobe, vector at the ack edge
   always @(posedge i_clk_sys) begin
      if (rd_seen) cmp({2'h0, o_rdata}, exp_rd.size() != 0 ? exp_rd.pop_front() : 10'h3ff);
      if (i_irq_ack && o_irq_req) begin
         cmp(o_irq_vector, exp_vec.size() != 0 ? exp_vec.pop_front() : 10'h3ff);
      end
      if (ack_seen) cmp({9'h0, o_global_enable}, 10'h000);
      rd_seen <= i_rd;
      ack_seen <= i_irq_ack && o_irq_req;
   end

   initial begin
      cyc(5000);
      num_errors++;
      stop_test();
   end

   initial begin
      cyc(20);
      i_rst_b <= 1'b1;
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h00);
      rv = 8'($random(seed));
      wr(2'h0, rv);
      rd(2'h0, rv);
      wr(2'h0, rv & 8'h0f);
      wr(2'h1, 8'hff);
      rd(2'h1, 8'h00);
      // every sense code on both pins, enables kept off while sense changes
      for (int p = 0; p < 2; p++) begin
         fmask = (p == 1) ? 8'h80 : 8'h40;
         for (int m = 0; m < 4; m++) begin
            w = 2 + ($unsigned($random(seed)) % 4);
            wr(2'h0, (p == 1) ? 8'(m << 2) : 8'(m));
            wr(2'h1, 8'hd0);
            setpin(p, 1'b0);
            cyc(4 + w);
            rd(2'h1, (m == 1 || m == 2) ? fmask : 8'h00);
            wr(2'h1, 8'hd0);
            setpin(p, 1'b1);
            cyc(4 + w);
            rd(2'h1, (m == 1 || m == 3) ? fmask : 8'h00);
         end
      end
      // pending flags while globally disabled, then served by priority
      wr(2'h0, 8'h0e);
      wr(2'h0, 8'hde);
      setpin(0, 1'b0);
      setpin(1, 1'b0);
      cyc(4);
      setpin(1, 1'b1);
      i_timer_overflow <= 1'b1;
      @(posedge i_clk_sys);
      i_timer_overflow <= 1'b0;
      cyc(6);
      rd(2'h1, 8'hd0);
      wr(2'h1, 8'h00);
      rd(2'h1, 8'hd0);
      wr(2'h1, 8'h10);
      rd(2'h1, 8'hc0);
      ack_delay <= 3'($random(seed));
      exp_vec.push_back(10'h001);
      exp_vec.push_back(10'h002);
      wr(2'h2, 8'h80);
      wait_done();
      setpin(0, 1'b1);
      exp_vec.push_back(10'h004);
      i_timer_overflow <= 1'b1;
      @(posedge i_clk_sys);
      i_timer_overflow <= 1'b0;
      wait_done();
      rd(2'h1, 8'h00);
      // level sensing on pin 0: request only while low
      wr(2'h0, 8'h0e);
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h40);
      ack_delay <= 3'h7;
      exp_vec.push_back(10'h001);
      setpin(0, 1'b0);
      wait_taken();
      // release before the handler returns, or the held level asks again
      setpin(0, 1'b1);
      cyc(20);
      // port low level, then the same pin masked by a special function
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h20);
      ack_delay <= 3'h0;
      exp_vec.push_back(10'h003);
      i_port_pins <= 8'hdf;
      wait_taken();
      i_port_pins <= 8'hff;
      cyc(20);
      i_special_fn_mask <= 8'h20;
      i_port_pins <= 8'hdf;
      cyc(30);
      // mask kept until the synchronised port is high again
      i_port_pins <= 8'hff;
      cyc(3);
      i_special_fn_mask <= 8'h00;
      rd(2'h2, 8'h80);
      cyc(4);
      stop_test();
   end
endmodule
`default_nettype wire
